// ---- rtl/rssc_pkg.sv ----
// Constants and types of the radio serial setup port
// Function
// (R1) Sixteen-bit words, most significant bit first
// (R2) One bit shifted per serial clock rise
// (R3) Enable rising edge commits the shifted word
// (R4) Bit zero picks setup or mode register
// (R5) Registers keep values through section power-down
// (R6) Controller writes setup word before use
// (R7) Setup word field layout as listed
// (R8) Receive sense: zero high-active, one low-active
// (R9) Transmit sense: zero high-active, one low-active
// (R10) Synth sense inverted: zero low-active
// (R11) Receive divider mode decode in receive slot
// (R12) Transmit divider bit, oscillator stays flywheeled
// (R13) Band switch high or low in receive; under serial control the code holds it low
// (R14) Control source: serial words or lines
// (R15) Channel always from serial mode word
// (R16) Pump test: tristate, up, down, normal
// (R17) Slicer bit: analog or sliced output
// (R18) Slicer forced off with IF strip down
// (R19) Controller programs M and A counters
// (R20) Demod mode: normal or S-field sample/hold
// (R21) Detector sense sets pump-up direction
// (R22) Reference select: 10.368 or 13.824 MHz
// (R23) Last sixteen bits used; other register kept
// (R24) Clock low while enable changes
package rssc_pkg;
    localparam int WORD_W = 16;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    // Register select values on bit zero
    localparam int SEL_BIT = 0;
    localparam logic SEL_SETUP = 1'b0;
    localparam logic SEL_MODE = 1'b1;
    // Setup word field positions
    localparam int RX_SENSE_BIT = 14;
    localparam int TX_SENSE_BIT = 13;
    localparam int SYN_SENSE_BIT = 12;
    localparam int RX_DIV_HI_BIT = 11;
    localparam int RX_DIV_LO_BIT = 10;
    localparam int TX_DIV_BIT = 9;
    localparam int BAND_SENSE_BIT = 8;
    localparam int CTRL_SRC_BIT = 7;
    localparam int PUMP_HI_BIT = 6;
    localparam int PUMP_LO_BIT = 5;
    localparam int SLICER_BIT = 4;
    localparam int DEMOD_BIT = 3;
    localparam int DET_SENSE_BIT = 2;
    localparam int REF_SEL_BIT = 1;
    // Mode word channel fields
    localparam int M_SEL_BIT = 15;
    localparam int A_HI_BIT = 14;
    localparam int A_LO_BIT = 10;
    localparam int A_W = 5;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        RSSC_PUMP_TRISTATE = 2'b00,
        RSSC_PUMP_UP = 2'b01,
        RSSC_PUMP_DOWN = 2'b10,
        RSSC_PUMP_NORMAL = 2'b11
    } rssc_pump_t;
endpackage

// ---- rtl/rssc_shifter.sv ----
// Serial-clock side shift register of the setup port
`timescale 1ns/100ps
module rssc_shifter #(
    parameter int WIDTH = rssc_pkg::WORD_W
) (
    input wire logic serial_clk,
    input wire logic reset_n,
    input wire logic serial_data,
    output logic [WIDTH-1:0] word_q
);
    if (WIDTH < 2) begin : g_width_chk
        $error("rssc_shifter: WIDTH too small");
    end

    // Older bits fall off the top, so only the last word counts
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= '0;
        end else begin
            word_q <= {word_q[WIDTH-2:0], serial_data}; // [R1] [R2] [R23]
        end
    end

    ////////////////////////////////////////////////////////////
    // Checked from the second edge on, so that history exists
    shift_in_a: assert property ( // [R2]
        @(posedge serial_clk) disable iff (!reset_n)
        1'b1 |=> word_q[0] == $past(serial_data)
            && word_q[WIDTH-1:1] == $past(word_q[WIDTH-2:0]))
        else $error("shift register did not take the data bit");
endmodule // rssc_shifter

// ---- rtl/rssc_top.sv ----
// Setup and mode registers with their decoded control outputs
`timescale 1ns/100ps
module rssc_top #(
    parameter int WORD_W = rssc_pkg::WORD_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic serial_enable,
    input wire logic transmit_line,
    input wire logic receive_line,
    input wire logic synth_line,
    input wire logic s_field_pin,
    input wire logic if_strip_on,
    input wire logic mode_rx_req,
    input wire logic mode_tx_req,
    input wire logic mode_syn_req,
    output logic [WORD_W-1:0] setup_word,
    output logic [WORD_W-1:0] mode_word,
    output logic setup_written,
    output logic rx_power,
    output logic tx_power,
    output logic synth_power,
    output logic divider_on,
    output logic vco_locked,
    output logic band_switch,
    output logic [1:0] pump_mode,
    output logic slicer_on,
    output logic demod_sample,
    output logic demod_hold,
    output logic pump_up_on_vco_high,
    output logic ref_select,
    output logic m_select,
    output logic [rssc_pkg::A_W-1:0] a_count
);
    // Field positions are fixed, so only the sixteen-bit word is served
    if (WORD_W != rssc_pkg::WORD_W) begin : g_width_chk
        $error("rssc_top: word width must be 16");
    end

    ////////////////////////////////////////////////////////////
    // Link side
    logic [WORD_W-1:0] shift_word;

    rssc_shifter #(
        .WIDTH(WORD_W)
    ) u_shifter (
        .serial_clk(serial_clk),
        .reset_n(reset_n),
        .serial_data(serial_data),
        .word_q(shift_word)
    );

    ////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic en_s1_q;
    logic en_s2_q;
    logic en_s3_q;
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic en_rise;
    logic rx_line_s;
    logic tx_line_s;
    logic syn_line_s;
    logic sfield_s;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_s3_q <= 1'b0;
        end else begin
            en_s1_q <= serial_enable;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {s_field_pin, synth_line, transmit_line, receive_line};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign en_rise = en_s2_q & ~en_s3_q;
    assign rx_line_s = pin_s2_q[0];
    assign tx_line_s = pin_s2_q[1];
    assign syn_line_s = pin_s2_q[2];
    assign sfield_s = pin_s2_q[3];

    ////////////////////////////////////////////////////////////
    // Word commit
    // The serial clock is idle while enable is high, so the word is
    // settled well before the synchronised edge reads it.
    logic [WORD_W-1:0] setup_q;
    logic [WORD_W-1:0] mode_q;
    logic setup_done_q;
    logic sel_mode;

    assign sel_mode = shift_word[rssc_pkg::SEL_BIT] == rssc_pkg::SEL_MODE; // [R4]

    // No other path clears these, so power-down leaves them intact
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            setup_q <= rssc_pkg::WORD_RESET;
        end else if (en_rise && !sel_mode) begin
            setup_q <= shift_word; // [R3] [R4] [R5] [R23]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= rssc_pkg::WORD_RESET;
        end else if (en_rise && sel_mode) begin
            mode_q <= shift_word; // [R3] [R4] [R5] [R23]
        end
    end

    // Software can tell an unconfigured part from a configured one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            setup_done_q <= 1'b0;
        end else if (en_rise && !sel_mode) begin
            setup_done_q <= 1'b1; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////
    // Setup fields
    logic rx_sense;
    logic tx_sense;
    logic syn_sense;
    logic [1:0] rx_div;
    logic tx_div;
    logic band_sense;
    logic ctrl_lines;
    logic slicer_en;
    logic demod_sfield;

    assign rx_sense = setup_q[rssc_pkg::RX_SENSE_BIT]; // [R7]
    assign tx_sense = setup_q[rssc_pkg::TX_SENSE_BIT];
    assign syn_sense = setup_q[rssc_pkg::SYN_SENSE_BIT];
    assign rx_div = setup_q[rssc_pkg::RX_DIV_HI_BIT:rssc_pkg::RX_DIV_LO_BIT];
    assign tx_div = setup_q[rssc_pkg::TX_DIV_BIT];
    assign band_sense = setup_q[rssc_pkg::BAND_SENSE_BIT];
    assign ctrl_lines = setup_q[rssc_pkg::CTRL_SRC_BIT];
    assign slicer_en = setup_q[rssc_pkg::SLICER_BIT];
    assign demod_sfield = setup_q[rssc_pkg::DEMOD_BIT];

    ////////////////////////////////////////////////////////////
    // Section power
    logic rx_pwr_d;
    logic tx_pwr_d;
    logic syn_pwr_d;
    logic rx_pwr_q;
    logic tx_pwr_q;
    logic syn_pwr_q;

    always_comb begin
        if (ctrl_lines) begin
            rx_pwr_d = rx_line_s ^ rx_sense; // [R8] [R14]
            tx_pwr_d = tx_line_s ^ tx_sense; // [R9]
            syn_pwr_d = ~(syn_line_s ^ syn_sense); // [R10]
        end else begin
            rx_pwr_d = mode_rx_req; // [R14]
            tx_pwr_d = mode_tx_req;
            syn_pwr_d = mode_syn_req;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_pwr_q <= 1'b0;
            tx_pwr_q <= 1'b0;
            syn_pwr_q <= 1'b0;
        end else begin
            rx_pwr_q <= rx_pwr_d;
            tx_pwr_q <= tx_pwr_d;
            syn_pwr_q <= syn_pwr_d;
        end
    end

    ////////////////////////////////////////////////////////////
    // Dividers and band switch
    logic div_q;
    logic lock_q;
    logic band_q;

    // Receive takes priority if both slots are asked for at once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (rx_pwr_d) begin
            div_q <= rx_div != 2'b00; // [R11]
            lock_q <= rx_div[1];
        end else if (tx_pwr_d) begin
            div_q <= tx_div; // [R12]
            lock_q <= 1'b0;
        end else begin
            div_q <= syn_pwr_d;
            lock_q <= syn_pwr_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            band_q <= 1'b0;
        end else begin
            band_q <= ctrl_lines & rx_pwr_d & ~band_sense; // [R13]
        end
    end

    ////////////////////////////////////////////////////////////
    // Pump, slicer, demodulator, reference
    logic [1:0] pump_q;
    logic slicer_q;
    logic sample_q;
    logic hold_q;
    logic det_q;
    logic ref_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pump_q <= rssc_pkg::RSSC_PUMP_TRISTATE;
            det_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            pump_q <= setup_q[rssc_pkg::PUMP_HI_BIT:rssc_pkg::PUMP_LO_BIT]; // [R16]
            det_q <= ~setup_q[rssc_pkg::DET_SENSE_BIT]; // [R21]
            ref_q <= setup_q[rssc_pkg::REF_SEL_BIT]; // [R22]
        end
    end

    // Slicer off whenever the IF strip is down
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            slicer_q <= 1'b0;
        end else begin
            slicer_q <= slicer_en & if_strip_on; // [R17] [R18]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sample_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            sample_q <= demod_sfield & sfield_s; // [R20]
            hold_q <= demod_sfield & ~sfield_s;
        end
    end

    ////////////////////////////////////////////////////////////
    // Outputs
    assign setup_word = setup_q;
    assign mode_word = mode_q;
    assign setup_written = setup_done_q;
    assign rx_power = rx_pwr_q;
    assign tx_power = tx_pwr_q;
    assign synth_power = syn_pwr_q;
    assign divider_on = div_q;
    assign vco_locked = lock_q;
    assign band_switch = band_q;
    assign pump_mode = pump_q;
    assign slicer_on = slicer_q;
    assign demod_sample = sample_q;
    assign demod_hold = hold_q;
    assign pump_up_on_vco_high = det_q;
    assign ref_select = ref_q;
    // Channel comes only from the serial word, whatever the source
    assign m_select = mode_q[rssc_pkg::M_SEL_BIT]; // [R15]
    assign a_count = mode_q[rssc_pkg::A_HI_BIT:rssc_pkg::A_LO_BIT]; // [R15]

    ////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    setup_commit_a: assert property ( // [R3]
        en_rise && !sel_mode |=> setup_q == $past(shift_word))
        else $error("setup word not committed");

    mode_commit_a: assert property ( // [R4]
        en_rise && sel_mode |=> mode_q == $past(shift_word) && $stable(setup_q))
        else $error("mode word not committed or setup disturbed");

    mode_kept_a: assert property ( // [R23]
        !en_rise |=> $stable(mode_q) && $stable(setup_q))
        else $error("register changed without an enable edge");

    rx_sense_a: assert property ( // [R8]
        ctrl_lines && $stable(ctrl_lines) |=> rx_power == ($past(rx_line_s) ^ $past(rx_sense)))
        else $error("receive power does not follow line sense");

    syn_sense_a: assert property ( // [R10]
        ctrl_lines && syn_sense && syn_line_s |=> synth_power)
        else $error("synth not powered on high line with sense one");

    rx_div_a: assert property ( // [R11]
        rx_pwr_d && rx_div == 2'b01 |=> divider_on && !vco_locked)
        else $error("receive divider mode decode wrong");

    tx_div_a: assert property ( // [R12]
        !rx_pwr_d && tx_pwr_d |=> !vco_locked && divider_on == $past(tx_div))
        else $error("transmit divider mode decode wrong");

    band_sw_a: assert property ( // [R13]
        ctrl_lines && rx_pwr_d && !band_sense |=> band_switch)
        else $error("band switch not high in receive");

    slicer_off_a: assert property ( // [R18]
        !if_strip_on |=> !slicer_on)
        else $error("slicer on while IF strip down");

    pump_test_a: assert property ( // [R16]
        pump_mode == rssc_pkg::RSSC_PUMP_NORMAL |-> $past(setup_q[6:5]) == 2'b11)
        else $error("pump normal without both test bits set");

    sfield_a: assert property ( // [R20]
        demod_sfield && sfield_s |=> demod_sample && !demod_hold)
        else $error("S-field sampling not taken");

    tx_sense_a: assert property ( // [R9]
        ctrl_lines && $stable(ctrl_lines) |=> tx_power == ($past(tx_line_s) ^ $past(tx_sense)))
        else $error("transmit power does not follow line sense");

    serial_src_a: assert property ( // [R14]
        !ctrl_lines |=> rx_power == $past(mode_rx_req) && synth_power == $past(mode_syn_req))
        else $error("section power does not follow serial requests");

    band_low_a: assert property ( // [R13]
        ctrl_lines && rx_pwr_d && band_sense |=> !band_switch)
        else $error("band switch not low in receive with sense one");

    slicer_on_a: assert property ( // [R17]
        slicer_en && if_strip_on |=> slicer_on)
        else $error("slicer not enabled with IF strip up");

    ref_sel_a: assert property ( // [R22]
        1'b1 |=> ref_select == $past(setup_q[rssc_pkg::REF_SEL_BIT]))
        else $error("reference select does not follow setup bit");

    setup_cov: cover property (en_rise && !sel_mode);
    mode_cov: cover property (en_rise && sel_mode);
    lines_cov: cover property (ctrl_lines && rx_power);
    sample_cov: cover property (demod_sample);
    tx_cov: cover property (tx_power && divider_on);
endmodule // rssc_top

// ---- tb/rssc_ctrl_model.sv ----
// Baseband controller model driving the three-wire serial port
`timescale 1ns/100ps
module rssc_ctrl_model (
    output logic serial_clk,
    output logic serial_data,
    output logic serial_enable
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        serial_enable = 1'b0;
    end
    // Link clock runs only inside a frame; 15 ns period
    task automatic send(input logic [19:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #7.5 serial_clk = 1'b1;
            #7.5 serial_clk = 1'b0;
        end
        // Released data line shows the inverse, not a stale bit
        serial_data = ~serial_data;
        #10 serial_enable = 1'b1;
        #80 serial_enable = 1'b0;
        #40;
    endtask
endmodule // rssc_ctrl_model

// ---- tb/test_radio_serial_setup_control.sv ----
// Self-checking bench of the radio serial setup port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_radio_serial_setup_control;
    logic clk_sys, reset_n, serial_clk, serial_data, serial_enable;
    logic transmit_line, receive_line, synth_line, s_field_pin, if_strip_on;
    logic mode_rx_req, mode_tx_req, mode_syn_req;
    logic [15:0] setup_word, mode_word;
    logic setup_written, rx_power, tx_power, synth_power, divider_on, vco_locked;
    logic band_switch, slicer_on, demod_sample, demod_hold, pump_up_on_vco_high;
    logic ref_select, m_select;
    logic [1:0] pump_mode;
    logic [rssc_pkg::A_W-1:0] a_count;
    int error_cnt = 0;
    int samples_checked = 0;
    rssc_ctrl_model rssc_ctrl_model_inst (.serial_clk(serial_clk), .serial_data(serial_data),
        .serial_enable(serial_enable));
    rssc_top rssc_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .serial_enable(serial_enable),
        .transmit_line(transmit_line), .receive_line(receive_line), .synth_line(synth_line),
        .s_field_pin(s_field_pin), .if_strip_on(if_strip_on), .mode_rx_req(mode_rx_req),
        .mode_tx_req(mode_tx_req), .mode_syn_req(mode_syn_req), .setup_word(setup_word),
        .mode_word(mode_word), .setup_written(setup_written), .rx_power(rx_power),
        .tx_power(tx_power), .synth_power(synth_power), .divider_on(divider_on),
        .vco_locked(vco_locked), .band_switch(band_switch), .pump_mode(pump_mode),
        .slicer_on(slicer_on), .demod_sample(demod_sample), .demod_hold(demod_hold),
        .pump_up_on_vco_high(pump_up_on_vco_high), .ref_select(ref_select),
        .m_select(m_select), .a_count(a_count));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Whole word plus sync and decode latency
    task automatic wr(input logic [19:0] w, input int n);
        rssc_ctrl_model_inst.send(w, n);
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic pins(input logic rx, input logic tx, input logic syn);
        @(negedge clk_sys);
        receive_line = rx;
        transmit_line = tx;
        synth_line = syn;
        repeat (5) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_setup();
        // Pump down, slicer on, detector sense 1, 13.824 MHz reference
        wr(20'h00056, 16);
        `CHK("setup_word", 16'h0056, setup_word)
        `CHK("setup_written", 1'b1, setup_written)
        `CHK("mode_word", 16'h0000, mode_word)
        `CHK("pump_mode", 2'b10, pump_mode)
        `CHK("pump_up_on_vco_high", 1'b0, pump_up_on_vco_high)
        `CHK("ref_select", 1'b1, ref_select)
        for (int p = 0; p < 4; p++) begin
            wr({13'h0, p[1:0], 5'h00}, 16);
            `CHK("pump_mode", p[1:0], pump_mode)
            `CHK("pump_up_on_vco_high", 1'b1, pump_up_on_vco_high)
        end
    endtask
    task automatic test_mode();
        // Receive channel 3, 110.592 MHz IF: M 32, A 10-3
        wr(20'h01c01, 16);
        `CHK("mode_word", 16'h1c01, mode_word)
        `CHK("m_select", 1'b0, m_select)
        `CHK("a_count", 5'h07, a_count)
        `CHK("setup_word", 16'h0060, setup_word)
        // Twenty bits clocked: only the last sixteen count
        wr(20'hf8c03, 20);
        `CHK("mode_word", 16'h8c03, mode_word)
        `CHK("m_select", 1'b1, m_select)
        `CHK("a_count", 5'h03, a_count)
    endtask
    task automatic test_lines();
        @(negedge clk_sys);
        mode_rx_req = 1'b1;
        mode_syn_req = 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        `CHK("rx_power", 1'b1, rx_power)
        `CHK("tx_power", 1'b0, tx_power)
        `CHK("synth_power", 1'b1, synth_power)
        // Line control, receive sense low-active, pump normal
        wr(20'h040e0, 16);
        pins(1'b0, 1'b1, 1'b1);
        `CHK("rx_power", 1'b1, rx_power)
        `CHK("tx_power", 1'b1, tx_power)
        `CHK("synth_power", 1'b0, synth_power)
        `CHK("divider_on", 1'b0, divider_on)
        `CHK("band_switch", 1'b1, band_switch)
        pins(1'b1, 1'b0, 1'b0);
        `CHK("rx_power", 1'b0, rx_power)
        `CHK("tx_power", 1'b0, tx_power)
        `CHK("synth_power", 1'b1, synth_power)
        `CHK("setup_word", 16'h40e0, setup_word)
        `CHK("a_count", 5'h03, a_count)
        // Receive dividers locked, transmit dividers on
        wr(20'h04ae0, 16);
        pins(1'b0, 1'b0, 1'b1);
        `CHK("divider_on", 1'b1, divider_on)
        `CHK("vco_locked", 1'b1, vco_locked)
        pins(1'b1, 1'b1, 1'b1);
        `CHK("tx_power", 1'b1, tx_power)
        `CHK("divider_on", 1'b1, divider_on)
        `CHK("vco_locked", 1'b0, vco_locked)
    endtask
    task automatic test_slicer();
        wr(20'h00018, 16);
        @(negedge clk_sys);
        if_strip_on = 1'b1;
        s_field_pin = 1'b1;
        repeat (5) @(negedge clk_sys);
        `CHK("slicer_on", 1'b1, slicer_on)
        `CHK("demod_sample", 1'b1, demod_sample)
        `CHK("demod_hold", 1'b0, demod_hold)
        if_strip_on = 1'b0;
        s_field_pin = 1'b0;
        repeat (5) @(negedge clk_sys);
        `CHK("slicer_on", 1'b0, slicer_on)
        `CHK("demod_sample", 1'b0, demod_sample)
        `CHK("demod_hold", 1'b1, demod_hold)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        {transmit_line, receive_line, synth_line, s_field_pin, if_strip_on} = 5'h00;
        {mode_rx_req, mode_tx_req, mode_syn_req} = 3'h0;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("setup_written", 1'b0, setup_written)
        test_setup();
        test_mode();
        test_lines();
        test_slicer();
        report_and_stop();
    end
    // Whole run is well under 20 us
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule // test_radio_serial_setup_control
